// ===== verilog/aocr_pkg.sv
// Register map, field layout and shared types for the output config bank
package aocr_pkg;
    // Register addresses on the serial configuration port
    localparam logic [7:0] ADDR_SOFT_RESET  = 8'h00;
    localparam logic [7:0] ADDR_CHAN_A_PAT  = 8'h25;
    localparam logic [7:0] ADDR_FORMAT      = 8'h29;
    localparam logic [7:0] ADDR_CHAN_B      = 8'h2b;
    localparam logic [7:0] ADDR_OFFSET_FIX  = 8'h3d;
    localparam logic [7:0] ADDR_WORD_HIGH   = 8'h3f;
    localparam logic [7:0] ADDR_WORD_LOW    = 8'h40;
    localparam logic [7:0] ADDR_PORT_CTRL   = 8'h41;
    localparam logic [7:0] ADDR_CLK_EDGE    = 8'h42;

    // Value after reset of every register in this bank
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int PAT_LSB       = 0;
    localparam int FORMAT_LSB    = 3;
    localparam int GAIN_LSB      = 4;
    localparam int OFFSET_BIT    = 5;
    localparam int SOFT_RST_BIT  = 1;
    localparam int IFACE_LSB     = 6;
    localparam int DRIVE_LSB     = 4;
    localparam int BUFOFF_LSB    = 0;
    localparam int FALL_LSB      = 6;
    localparam int RISE_LSB      = 4;
    localparam int DIGEN_BIT     = 3;
    localparam int WORD_HIGH_W   = 6;

    // Writable bit masks; reserved bits are held at zero
    localparam logic [7:0] MASK_CHAN_A_PAT = 8'h07;
    localparam logic [7:0] MASK_FORMAT     = 8'h18;
    localparam logic [7:0] MASK_CHAN_B     = 8'hf7;
    localparam logic [7:0] MASK_OFFSET_FIX = 8'h20;
    localparam logic [7:0] MASK_WORD_HIGH  = 8'h3f;
    localparam logic [7:0] MASK_WORD_LOW   = 8'hff;
    localparam logic [7:0] MASK_PORT_CTRL  = 8'hf3;
    localparam logic [7:0] MASK_CLK_EDGE   = 8'hf8;

    // Fixed data words
    localparam logic [13:0] TOGGLE_A     = 14'h2aaa;
    localparam logic [13:0] TOGGLE_B     = 14'h1555;
    localparam logic [13:0] WORD_ZEROS   = 14'h0000;
    localparam logic [13:0] WORD_ONES    = 14'h3fff;
    localparam logic [3:0]  GAIN_MAX     = 4'hc;

    // Two-bit codes
    localparam logic [1:0] SEL_ALT       = 2'h3;
    localparam logic [1:0] BUFOFF_B      = 2'h1;
    localparam logic [1:0] BUFOFF_A      = 2'h2;
    localparam logic [1:0] BUFOFF_ALL    = 2'h3;
    localparam logic [1:0] EDGE_FORBID   = 2'h2;

    // Test pattern selection codes
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'h0,
        PAT_ZEROS  = 3'h1,
        PAT_ONES   = 3'h2,
        PAT_TOGGLE = 3'h3,
        PAT_RAMP   = 3'h4,
        PAT_CUSTOM = 3'h5
    } aocr_pattern_type;

    // Serial port write request
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } aocr_write_type;

    // Decoded settings presented to the datapath
    typedef struct packed {
        logic        twos_comp;
        logic        cmos_mode;
        logic [1:0]  single_ended_clk_drive;
        logic        chan_a_buf_off;
        logic        chan_b_buf_off;
        logic        clk_buf_off;
        logic [1:0]  out_clk_fall_shift;
        logic [1:0]  out_clk_rise_shift;
        logic        offset_fix_on;
        logic [3:0]  chan_b_gain_code;
        logic        digital_on;
    } aocr_config_type;
endpackage : aocr_pkg

// ===== verilog/aocr_regs.sv
// Output path configuration registers with test pattern generation
//
// Function
// - Channel A three-bit pattern: normal, zeros, ones, toggle, ramp, custom.
// - Toggle pattern alternates 2AAAh and 1555h on successive samples.
// - Channel B pattern field uses the same encodings as channel A.
// - Format field 11 gives offset binary, other values twos complement.
// - Channel B gain nibble, half-decibel steps, 0000 to 1100.
// - Offset register bit 5 enables offset correction.
// - Custom word: 3Fh bits 5..0 high, 40h bits 7..0 low.
// - Interface field 11 selects parallel CMOS, other values DDR LVDS.
// - Two-bit CMOS output clock drive strength, 00 maximum.
// - Buffer-off: 01 chan B, 10 chan A, 11 both plus clock.
// - Digital enable bit 3 must be set for patterns, gain, offset.
// - Every register in this bank reads 00h after reset.
// - Software reset bit restores defaults and clears itself.
// - One write updates all fields of a register together.
`timescale 1ns/1ns
module aocr_regs #(
    parameter int DATA_W = 14
) (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire aocr_pkg::aocr_write_type wr,
    input  wire logic [7:0]               rd_addr,
    output logic [7:0]                    rd_data,
    input  wire logic                     sample_en,
    input  wire logic [DATA_W-1:0]        conv_a,
    input  wire logic [DATA_W-1:0]        conv_b,
    output logic [DATA_W-1:0]             out_a,
    output logic [DATA_W-1:0]             out_b,
    output logic                          out_a_en,
    output logic                          out_b_en,
    output logic                          out_clk_en,
    output aocr_pkg::aocr_config_type     cfg,
    output logic                          edge_code_illegal
);

    // Datapath is fixed at fourteen bits: the toggle, all-ones and custom
    // words are built for that width, so any other width is refused
    if (DATA_W != 14) begin : g_width_check
        $error("aocr_regs supports only DATA_W of 14");
    end

    // Stored bytes; reserved bit positions always hold zero
    logic [7:0] chan_a_pat;
    logic [7:0] fmt;
    logic [7:0] chan_b;
    logic [7:0] offset_fix;
    logic [7:0] word_high;
    logic [7:0] word_low;
    logic [7:0] port_ctrl;
    logic [7:0] clk_edge;

    // Next values from the write decode
    logic [7:0] next_chan_a_pat;
    logic [7:0] next_fmt;
    logic [7:0] next_chan_b;
    logic [7:0] next_offset_fix;
    logic [7:0] next_word_high;
    logic [7:0] next_word_low;
    logic [7:0] next_port_ctrl;
    logic [7:0] next_clk_edge;

    // Pulse from a write of the software reset bit
    logic       soft_reset;

    // Masked write: reserved bits are stored as zero whatever the host sends
    function automatic logic [7:0] masked(input logic [7:0] d,
                                          input logic [7:0] m);
        masked = d & m;
    endfunction : masked

    // Per-channel buffer-off: its own code, or 11 which takes everything
    function automatic logic chan_off(input logic [1:0] code,
                                      input logic [1:0] own);
        chan_off = code == own || code == aocr_pkg::BUFOFF_ALL;
    endfunction : chan_off

    // Two-bit selects in which only 11 picks the alternative setting
    function automatic logic alt_code(input logic [1:0] code);
        alt_code = code == aocr_pkg::SEL_ALT;
    endfunction : alt_code

    // Edge code 10 has no defined placement in CMOS mode
    function automatic logic edge_forbidden(input logic [1:0] code);
        edge_forbidden = code == aocr_pkg::EDGE_FORBID;
    endfunction : edge_forbidden

    // Gain codes above six decibels have no defined step, so they clamp
    function automatic logic [3:0] clamp_gain(input logic [3:0] code);
        clamp_gain = code > aocr_pkg::GAIN_MAX ? aocr_pkg::GAIN_MAX
                                               : code;
    endfunction : clamp_gain

    // Pattern word for one channel given its code and sample phase
    function automatic logic [DATA_W-1:0] pattern_word(
        input logic [2:0]        code,
        input logic [DATA_W-1:0] conv,
        input logic              phase,
        input logic [DATA_W-1:0] ramp,
        input logic [DATA_W-1:0] custom,
        input logic              dig_on,
        input logic              offset_bin);
        logic [DATA_W-1:0] w;
        w = conv;
        if (dig_on) begin
            unique case (code)
                aocr_pkg::PAT_ZEROS:  w = aocr_pkg::WORD_ZEROS;
                aocr_pkg::PAT_ONES:   w = aocr_pkg::WORD_ONES;
                aocr_pkg::PAT_TOGGLE: w = phase ? aocr_pkg::TOGGLE_B
                                                : aocr_pkg::TOGGLE_A;
                aocr_pkg::PAT_RAMP:   w = ramp;
                aocr_pkg::PAT_CUSTOM: w = custom;
                default:              w = conv; // Normal and unused codes
            endcase
        end
        // Offset binary flips the sign bit of twos complement data
        if (offset_bin) begin
            w[DATA_W-1] = ~w[DATA_W-1];
        end
        pattern_word = w;
    endfunction : pattern_word

    // Soft reset pulse: the bit never stores, so it reads back as zero
    assign soft_reset = wr.valid && wr.addr == aocr_pkg::ADDR_SOFT_RESET
                        && wr.data[aocr_pkg::SOFT_RST_BIT];

    // Next register values; whole byte replaced at once
    // Reserved bits are masked on the way in so readback shows zeros
    always_comb begin
        // Every byte holds unless written
        next_chan_a_pat = chan_a_pat;
        next_fmt        = fmt;
        next_chan_b     = chan_b;
        next_offset_fix = offset_fix;
        next_word_high  = word_high;
        next_word_low   = word_low;
        next_port_ctrl  = port_ctrl;
        next_clk_edge   = clk_edge;
        // Software reset returns every byte here to its reset value
        if (soft_reset) begin
            next_chan_a_pat = aocr_pkg::REG_RESET;
            next_fmt        = aocr_pkg::REG_RESET;
            next_chan_b     = aocr_pkg::REG_RESET;
            next_offset_fix = aocr_pkg::REG_RESET;
            next_word_high  = aocr_pkg::REG_RESET;
            next_word_low   = aocr_pkg::REG_RESET;
            next_port_ctrl  = aocr_pkg::REG_RESET;
            next_clk_edge   = aocr_pkg::REG_RESET;
        end else if (wr.valid) begin
            unique case (wr.addr)
                aocr_pkg::ADDR_CHAN_A_PAT: next_chan_a_pat =
                    masked(wr.data, aocr_pkg::MASK_CHAN_A_PAT);
                aocr_pkg::ADDR_FORMAT: next_fmt =
                    masked(wr.data, aocr_pkg::MASK_FORMAT);
                aocr_pkg::ADDR_CHAN_B: next_chan_b =
                    masked(wr.data, aocr_pkg::MASK_CHAN_B);
                aocr_pkg::ADDR_OFFSET_FIX: next_offset_fix =
                    masked(wr.data, aocr_pkg::MASK_OFFSET_FIX);
                aocr_pkg::ADDR_WORD_HIGH: next_word_high =
                    masked(wr.data, aocr_pkg::MASK_WORD_HIGH);
                aocr_pkg::ADDR_WORD_LOW: next_word_low =
                    masked(wr.data, aocr_pkg::MASK_WORD_LOW);
                aocr_pkg::ADDR_PORT_CTRL: next_port_ctrl =
                    masked(wr.data, aocr_pkg::MASK_PORT_CTRL);
                aocr_pkg::ADDR_CLK_EDGE: next_clk_edge =
                    masked(wr.data, aocr_pkg::MASK_CLK_EDGE);
                default: ; // Other addresses belong to neighbouring banks
            endcase
        end
    end

    // Register storage, cleared by the pin reset
    // Only constants in the reset branch, so it stays a true async clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            chan_a_pat <= aocr_pkg::REG_RESET;
            fmt        <= aocr_pkg::REG_RESET;
            chan_b     <= aocr_pkg::REG_RESET;
            offset_fix <= aocr_pkg::REG_RESET;
            word_high  <= aocr_pkg::REG_RESET;
            word_low   <= aocr_pkg::REG_RESET;
            port_ctrl  <= aocr_pkg::REG_RESET;
            clk_edge   <= aocr_pkg::REG_RESET;
        end else begin
            chan_a_pat <= next_chan_a_pat;
            fmt        <= next_fmt;
            chan_b     <= next_chan_b;
            offset_fix <= next_offset_fix;
            word_high  <= next_word_high;
            word_low   <= next_word_low;
            port_ctrl  <= next_port_ctrl;
            clk_edge   <= next_clk_edge;
        end
    end

    // Readback mux; unmapped addresses read zero
    // Combinational so a read answers in the cycle it is asked
    always_comb begin
        unique case (rd_addr)
            aocr_pkg::ADDR_CHAN_A_PAT: rd_data = chan_a_pat;
            aocr_pkg::ADDR_FORMAT:     rd_data = fmt;
            aocr_pkg::ADDR_CHAN_B:     rd_data = chan_b;
            aocr_pkg::ADDR_OFFSET_FIX: rd_data = offset_fix;
            aocr_pkg::ADDR_WORD_HIGH:  rd_data = word_high;
            aocr_pkg::ADDR_WORD_LOW:   rd_data = word_low;
            aocr_pkg::ADDR_PORT_CTRL:  rd_data = port_ctrl;
            aocr_pkg::ADDR_CLK_EDGE:   rd_data = clk_edge;
            // Address 00h lands here too: the reset bit never stores
            default:                   rd_data = 8'h00;
        endcase
    end

    // Field decode
    logic [1:0]        bufoff;
    logic [1:0]        iface;
    logic [DATA_W-1:0] custom_word;
    logic [3:0]        gain_raw;
    always_comb begin
        // Raw fields pulled out of the stored bytes
        bufoff      = port_ctrl[aocr_pkg::BUFOFF_LSB +: 2];
        iface       = port_ctrl[aocr_pkg::IFACE_LSB +: 2];
        custom_word = {word_high[aocr_pkg::WORD_HIGH_W-1:0],
                       word_low};
        gain_raw    = chan_b[aocr_pkg::GAIN_LSB +: 4];
        // Output coding and interface choice
        cfg.twos_comp = !alt_code(fmt[aocr_pkg::FORMAT_LSB +: 2]);
        cfg.cmos_mode = alt_code(iface);
        cfg.single_ended_clk_drive =
            port_ctrl[aocr_pkg::DRIVE_LSB +: 2];
        // Buffer power-down; the clock buffer goes only with code 11
        cfg.chan_b_buf_off = chan_off(bufoff, aocr_pkg::BUFOFF_B);
        cfg.chan_a_buf_off = chan_off(bufoff, aocr_pkg::BUFOFF_A);
        cfg.clk_buf_off    = bufoff == aocr_pkg::BUFOFF_ALL;
        // Clock edge placement passes straight through to the edge logic
        cfg.out_clk_fall_shift = clk_edge[aocr_pkg::FALL_LSB +: 2];
        cfg.out_clk_rise_shift = clk_edge[aocr_pkg::RISE_LSB +: 2];
        cfg.digital_on = clk_edge[aocr_pkg::DIGEN_BIT];
        // Gain and offset take effect only with digital functions on
        cfg.offset_fix_on = offset_fix[aocr_pkg::OFFSET_BIT]
                            && cfg.digital_on;
        cfg.chan_b_gain_code = cfg.digital_on ? clamp_gain(gain_raw)
                                              : 4'h0;
        // Status only: a forbidden code is stored, the host must fix it
        edge_code_illegal = cfg.cmos_mode &&
            (edge_forbidden(cfg.out_clk_fall_shift) ||
             edge_forbidden(cfg.out_clk_rise_shift));
    end

    // Sample-rate pattern state: toggle phase and ramp counter
    // Both advance on every sample, whichever pattern is selected
    logic              phase;
    logic              next_phase;
    logic [DATA_W-1:0] ramp;
    logic [DATA_W-1:0] next_ramp;
    // Output words, held between samples
    logic [DATA_W-1:0] next_out_a;
    logic [DATA_W-1:0] next_out_b;
    always_comb begin
        next_phase = phase;
        next_ramp  = ramp;
        next_out_a = out_a;
        next_out_b = out_b;
        if (soft_reset) begin
            // Restart both sequences; the output words keep their last value
            next_phase = 1'b0;
            next_ramp  = aocr_pkg::WORD_ZEROS;
        end else if (sample_en) begin
            next_phase = ~phase;
            next_ramp  = ramp + 14'h0001; // Wraps naturally
            // Both channels share one phase and ramp so they stay aligned
            next_out_a = pattern_word(chan_a_pat[2:0], conv_a, phase, ramp,
                custom_word, cfg.digital_on, !cfg.twos_comp);
            next_out_b = pattern_word(chan_b[2:0], conv_b, phase, ramp,
                custom_word, cfg.digital_on, !cfg.twos_comp);
        end
    end

    // Output data registers; soft reset also restarts the ramp
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase <= 1'b0;
            ramp  <= aocr_pkg::WORD_ZEROS;
            out_a <= aocr_pkg::WORD_ZEROS;
            out_b <= aocr_pkg::WORD_ZEROS;
        end else begin
            phase <= next_phase;
            ramp  <= next_ramp;
            out_a <= next_out_a;
            out_b <= next_out_b;
        end
    end

    // Buffer enables, high while the buffer drives
    assign out_a_en   = !cfg.chan_a_buf_off;
    assign out_b_en   = !cfg.chan_b_buf_off;
    // Clock buffer stays on unless both data buffers are off too
    assign out_clk_en = !cfg.clk_buf_off;

endmodule : aocr_regs

// ===== verif/aocr_regs_assertions.sv
// Port checks for the output configuration bank
`timescale 1ns/1ns
module aocr_assert #(
    parameter int DATA_W = 14
) (
    input wire logic                      mclk,
    input wire logic                      resetn,
    input wire aocr_pkg::aocr_write_type  wr,
    input wire logic                      sample_en,
    input wire logic [DATA_W-1:0]         out_a,
    input wire logic [DATA_W-1:0]         out_b,
    input wire logic                      out_a_en,
    input wire logic                      out_b_en,
    input wire logic                      out_clk_en,
    input wire aocr_pkg::aocr_config_type cfg,
    input wire logic                      edge_code_illegal
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Write decodes per register of interest
    logic wp;
    logic wf;
    logic we;
    logic ws;
    assign wp = wr.valid && wr.addr == 8'h41;
    assign wf = wr.valid && wr.addr == 8'h29;
    assign we = wr.valid && wr.addr == 8'h42;
    assign ws = wr.valid && wr.addr == 8'h00 && wr.data[1];

    a_iface_sel: assert property (
        wp |=> cfg.cmos_mode == ($past(wr.data[7:6]) == 2'h3))
        else $error("interface select wrong");
    a_buf_off: assert property (
        wp |=> out_a_en == !$past(wr.data[1]) && out_b_en == !$past(wr.data[0])
            && out_clk_en == ($past(wr.data[1:0]) != 2'h3))
        else $error("buffer enables wrong");
    a_clk_drive: assert property (
        wp |=> cfg.single_ended_clk_drive == $past(wr.data[5:4]))
        else $error("clock drive wrong");
    a_format_sel: assert property (
        wf |=> cfg.twos_comp == ($past(wr.data[4:3]) != 2'h3))
        else $error("format select wrong");
    a_dig_enable: assert property (
        we |=> cfg.digital_on == $past(wr.data[3]))
        else $error("digital enable wrong");
    a_dig_bypass: assert property (
        !cfg.digital_on |-> !cfg.offset_fix_on && cfg.chan_b_gain_code == 4'h0)
        else $error("gain or offset active while bypassed");
    a_edge_forbid: assert property (
        edge_code_illegal == (cfg.cmos_mode && (cfg.out_clk_fall_shift == 2'h2
            || cfg.out_clk_rise_shift == 2'h2)))
        else $error("edge code flag wrong");
    a_soft_clear: assert property (
        ws |=> !cfg.cmos_mode && !cfg.digital_on && out_a_en && out_clk_en)
        else $error("soft reset left settings");
    a_out_hold: assert property (
        !sample_en && !ws |=> $stable(out_a) && $stable(out_b))
        else $error("output changed without sample");
    // Main scenarios reached
    c_cmos: cover property (wp ##1 cfg.cmos_mode);
    c_soft: cover property (ws);
    c_sample: cover property (sample_en && cfg.digital_on);
endmodule : aocr_assert

bind aocr_regs aocr_assert #(.DATA_W(DATA_W)) i_chk (
    .mclk, .resetn, .wr, .sample_en, .out_a, .out_b, .out_a_en,
    .out_b_en, .out_clk_en, .cfg, .edge_code_illegal
);

// ===== verif/aocr_host.sv
// Host model driving the configuration write and read ports
`timescale 1ns/1ns
module aocr_host (
    input  wire logic                mclk,
    input  wire logic [7:0]          rd_data,
    output aocr_pkg::aocr_write_type wr,
    output logic [7:0]               rd_addr
);
    // Idle bus at start
    initial begin
        wr = '0;
        rd_addr = 8'h00;
    end
    // One-cycle strobe; released lines show the inverse, not old data
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= '{valid: 1'b1, addr: a, data: d}; // Data sent as given; the bank masks reserved bits
        @(posedge mclk);
        wr <= '{valid: 1'b0, addr: ~a, data: ~d};
    endtask : write_reg
    // Read data taken in the settled half of the cycle
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd_addr <= a;
        @(negedge mclk);
        d = rd_data;
    endtask : read_reg
endmodule : aocr_host

// ===== verif/adc_output_config_regs_tb.sv
// Directed bench for the output configuration register bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; \
    if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module adc_output_config_regs_tb;
    logic                      mclk;
    logic                      resetn;
    aocr_pkg::aocr_write_type  wr;
    logic [7:0]                rd_addr;
    logic [7:0]                rd_data;
    logic                      sample_en;
    logic [13:0]               conv_a;
    logic [13:0]               conv_b;
    logic [13:0]               out_a;
    logic [13:0]               out_b;
    logic                      out_a_en;
    logic                      out_b_en;
    logic                      out_clk_en;
    aocr_pkg::aocr_config_type cfg;
    logic                      edge_code_illegal;
    logic [7:0]                g;
    logic [1:0]                c;
    logic [13:0]               a0;
    logic [13:0]               b0;
    int                        failures;
    int                        cmp_count;

    aocr_host i_host (.mclk, .rd_data, .wr, .rd_addr);
    aocr_regs #(.DATA_W(14)) i_dut (
        .mclk, .resetn, .wr, .rd_addr, .rd_data, .sample_en, .conv_a,
        .conv_b, .out_a, .out_b, .out_a_en, .out_b_en, .out_clk_en, .cfg,
        .edge_code_illegal
    );
    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
        @(negedge mclk);
    endtask : wr_reg
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        i_host.read_reg(a, v);
        `CHK("readback", d, v)
    endtask : chk_rd
    // One sample pulse, outputs read once settled
    task automatic smp();
        @(posedge mclk);
        sample_en <= 1'b1;
        @(posedge mclk);
        sample_en <= 1'b0;
        @(negedge mclk);
    endtask : smp
    task automatic t_reset();
        logic [7:0] ad [10] = '{8'h25, 8'h29, 8'h2b, 8'h3d, 8'h3f,
                                8'h40, 8'h41, 8'h42, 8'h00, 8'h50};
        foreach (ad[i]) chk_rd(ad[i], 8'h00);
        `CHK("enables", 3'h7, {out_a_en, out_b_en, out_clk_en})
        $display("done: reset values");
    endtask : t_reset
    task automatic t_port();
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr_reg(8'h41, {c, c, 2'h0, c});
            g = {cfg.cmos_mode, cfg.single_ended_clk_drive, out_a_en,
                 out_b_en, out_clk_en};
            `CHK("port", {c == 2'h3, c, ~c, c < 2'h3}, g)
            chk_rd(8'h41, {c, c, 2'h0, c});
        end
        $display("done: port control");
    endtask : t_port
    task automatic t_edge();
        wr_reg(8'h41, 8'hc0);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr_reg(8'h42, {c, ~c, 4'h8});
            g = {3'h0, cfg.out_clk_fall_shift, cfg.out_clk_rise_shift,
                 edge_code_illegal};
            `CHK("edge", {c, ~c, c == 2'h1 || c == 2'h2}, g)
        end
        wr_reg(8'h42, 8'h88);
        wr_reg(8'h41, 8'h00);
        `CHK("edge lvds", 1'b0, edge_code_illegal)
        $display("done: clock edges");
    endtask : t_edge
    task automatic t_gain();
        wr_reg(8'h42, 8'h08);
        wr_reg(8'h2b, 8'hc0);
        wr_reg(8'h3d, 8'h20);
        g = {3'h0, cfg.chan_b_gain_code, cfg.offset_fix_on};
        `CHK("gain on", 8'h19, g)
        chk_rd(8'h3d, 8'h20);
        wr_reg(8'h2b, 8'hf0);
        `CHK("gain clamp", 4'hc, cfg.chan_b_gain_code)
        wr_reg(8'h42, 8'h00);
        g = {3'h0, cfg.chan_b_gain_code, cfg.offset_fix_on};
        `CHK("gain off", 8'h00, g)
        wr_reg(8'h3d, 8'h00);
        $display("done: gain and offset");
    endtask : t_gain
    function automatic logic [13:0] pat(input int k, input logic [13:0] v);
        return k == 1 ? 14'h0000 : k == 2 ? 14'h3fff : k == 5 ? 14'h15a5 : v;
    endfunction : pat
    task automatic t_pattern();
        wr_reg(8'h3f, 8'h15);
        wr_reg(8'h40, 8'ha5);
        wr_reg(8'h42, 8'h08);
        for (int k = 0; k < 8; k++) begin
            wr_reg(8'h25, 8'(k));
            wr_reg(8'h2b, 8'(k));
            smp();
            a0 = out_a;
            b0 = out_b;
            smp();
            if (k == 3) begin
                `CHK("toggle a", a0 ^ 14'h3fff, out_a)
                `CHK("toggle b", b0 ^ 14'h3fff, out_b)
                `CHK("toggle", 1'b1, a0 inside {14'h2aaa, 14'h1555})
            end else if (k == 4) begin
                `CHK("ramp a", a0 + 14'h1, out_a)
                `CHK("ramp b", b0 + 14'h1, out_b)
            end else begin
                `CHK("pattern a", pat(k, conv_a), out_a)
                `CHK("pattern b", pat(k, conv_b), out_b)
            end
        end
        chk_rd(8'h3f, 8'h15);
        wr_reg(8'h42, 8'h00);
        wr_reg(8'h25, 8'h02);
        smp();
        `CHK("bypass", conv_a, out_a)
        $display("done: test patterns");
    endtask : t_pattern
    task automatic t_format();
        wr_reg(8'h42, 8'h08);
        for (int f = 0; f < 4; f++) begin
            wr_reg(8'h29, {3'h0, 2'(f), 3'h0});
            smp();
            `CHK("format", f == 3 ? 14'h1fff : 14'h3fff, out_a)
        end
        $display("done: data format");
    endtask : t_format
    task automatic t_soft();
        wr_reg(8'h41, 8'hc3);
        wr_reg(8'h00, 8'h02);
        chk_rd(8'h41, 8'h00);
        chk_rd(8'h29, 8'h00);
        `CHK("soft enables", 3'h7, {out_a_en, out_b_en, out_clk_en})
        wr_reg(8'h42, 8'h08);
        wr_reg(8'h25, 8'h03);
        wr_reg(8'h2b, 8'h04);
        smp();
        `CHK("toggle start", 14'h2aaa, out_a)
        `CHK("ramp start", 14'h0000, out_b)
        smp();
        `CHK("toggle next", 14'h1555, out_a)
        `CHK("ramp next", 14'h0001, out_b)
        $display("done: soft reset");
    endtask : t_soft
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        conclude();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        sample_en = 1'b0;
        conv_a = 14'h1234;
        conv_b = 14'h0abc;
        failures = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        t_reset();
        t_port();
        t_edge();
        t_gain();
        t_pattern();
        t_format();
        t_soft();
        conclude();
    end
endmodule : adc_output_config_regs_tb
